// File: rtl/ors_relay_top.sv
// Purpose: drives one binary output relay from selectable internal signals
// Assumes: register port strobes are single cycles, never both at once
// Notes:   latch, switch-off delay and minimum hold run in that order
//
// Implementation choices: the address map and the address-and-strobe port.
module ors_relay_top #(
   parameter int unsigned TICK_CYCLES = ors_pkg::TICK_CYCLES // cycles per 10 ms step
) (
   // clock and reset
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_n_i,
   // register port
   input  wire logic [ors_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [ors_pkg::DATA_W-1:0] reg_wdata_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   output logic      [ors_pkg::DATA_W-1:0] reg_rdata_o,
   // internal signal pool
   input  wire logic [ors_pkg::POOL_W-1:0] sig_pool_i,
   // relay coil
   output logic                            relay_o
);
   import ors_pkg::*;

   localparam int unsigned PRE_W = $clog2(TICK_CYCLES);      // prescaler width
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

   // settings
   ors_src_cfg_t       src_cfg_q [NUM_SRC];                   // source assignments
   ors_src_cfg_t       ack_cfg_q;                             // acknowledgement source
   ors_ctrl_t          ctrl_q;                                // latch and invert
   logic [TIME_W-1:0]  thold_q;                               // minimum hold, steps
   logic [TIME_W-1:0]  toff_q;                                // switch-off delay, steps

   // datapath state
   logic [PRE_W-1:0]   pre_q;                                 // step prescaler
   logic               tick_q;                                // one pulse per step
   logic               latched_q;                             // latched pickup
   ors_dly_state_t     dly_q;                                 // switch-off stage
   ors_dly_state_t     dly_d;                                 // next switch-off state
   logic               relay_q;                               // relay as driven
   logic [DATA_W-1:0]  rdata_q;                               // read answer

   // combinational terms
   logic               coll;                                  // collective signal
   logic               ack;                                   // acknowledgement level
   logic               want;                                  // demand after latch
   logic               dly_on;                                // demand after delay
   logic               off_done;                              // delay has run out
   logic               hold_done;                             // hold time has run out
   logic               change;                                // relay toggles now

   // read word of a source selection
   function automatic logic [DATA_W-1:0] cfg_word(input ors_src_cfg_t c);
      logic [DATA_W-1:0] w;
      w = '0;
      w[CFG_EN_BIT]  = c.en;
      w[CFG_INV_BIT] = c.inv;
      w[IDX_W-1:0]   = c.idx;
      return w;
   endfunction : cfg_word

   // source selection from a written word
   function automatic ors_src_cfg_t word_cfg(input logic [DATA_W-1:0] w);
      ors_src_cfg_t c;
      c.en  = w[CFG_EN_BIT];
      c.inv = w[CFG_INV_BIT];
      c.idx = w[IDX_W-1:0];
      return c;
   endfunction : word_cfg

   // time setting from a written word, clamped to 300.00 s
   function automatic logic [TIME_W-1:0] word_time(input logic [DATA_W-1:0] w);
      logic [TIME_W-1:0] t;
      t = TIME_MAX;
      if (w <= DATA_W'(TIME_MAX)) begin
         t = w[TIME_W-1:0];
      end
      return t;
   endfunction : word_time

   // ------------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------------

   // one assignment register per source
   for (genvar g = 0; g < NUM_SRC; g++) begin : g_cfg
      localparam logic [ADDR_W-1:0] MY_ADDR = ADDR_W'(ADDR_ASSIGN0 + g * ADDR_STRIDE);
      // source select and inversion, both inactive after reset
      always_ff @(posedge core_clk_i) begin
         if (!rst_n_i) begin
            src_cfg_q[g] <= CFG_RST;
         end else if (reg_wr_i && reg_addr_i == MY_ADDR) begin
            src_cfg_q[g] <= word_cfg(reg_wdata_i);
         end
      end
   end

   // acknowledgement source select
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ack_cfg_q <= CFG_RST;
      end else if (reg_wr_i && reg_addr_i == ADDR_ACK) begin
         ack_cfg_q     <= word_cfg(reg_wdata_i);
         ack_cfg_q.inv <= 1'b0;                                   // no inversion here
      end
   end

   // latch enable and collective inversion, both off after reset
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ctrl_q <= CTRL_RST;
      end else if (reg_wr_i && reg_addr_i == ADDR_CTRL) begin
         ctrl_q.latch_en <= reg_wdata_i[CTRL_LATCH_BIT];
         ctrl_q.coll_inv <= reg_wdata_i[CTRL_CINV_BIT];
      end
   end

   // time settings, 0.00 s after reset
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         thold_q <= TIME_RST;
         toff_q  <= TIME_RST;
      end else if (reg_wr_i && reg_addr_i == ADDR_THOLD) begin
         thold_q <= word_time(reg_wdata_i);
      end else if (reg_wr_i && reg_addr_i == ADDR_TOFF) begin
         toff_q  <= word_time(reg_wdata_i);
      end
   end

   // ------------------------------------------------------------------
   // register reads: answer stands only in the cycle after the strobe
   // ------------------------------------------------------------------

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rdata_q <= '0;
      end else if (!reg_rd_i) begin
         rdata_q <= '0;                                           // idle bus reads zero
      end else if (reg_addr_i < ADDR_ACK && reg_addr_i[1:0] == 2'b00) begin
         rdata_q <= cfg_word(src_cfg_q[reg_addr_i[4:2]]);         // assignment n
      end else if (reg_addr_i == ADDR_ACK) begin
         rdata_q <= cfg_word(ack_cfg_q);
      end else if (reg_addr_i == ADDR_CTRL) begin
         rdata_q                 <= '0;
         rdata_q[CTRL_LATCH_BIT] <= ctrl_q.latch_en;
         rdata_q[CTRL_CINV_BIT]  <= ctrl_q.coll_inv;
      end else if (reg_addr_i == ADDR_THOLD) begin
         rdata_q <= DATA_W'(thold_q);
      end else if (reg_addr_i == ADDR_TOFF) begin
         rdata_q <= DATA_W'(toff_q);
      end else if (reg_addr_i == ADDR_STATUS) begin
         rdata_q                <= '0;
         rdata_q[STS_RELAY_BIT] <= relay_q;
         rdata_q[STS_LATCH_BIT] <= latched_q;
         rdata_q[STS_COLL_BIT]  <= coll;
         rdata_q[STS_DLY_BIT]   <= (dly_q == DLY_RUN);
         rdata_q[STS_HOLD_BIT]  <= ~hold_done;
      end else begin
         rdata_q <= '0;                                           // unmapped reads zero
      end
   end

   // ------------------------------------------------------------------
   // time base
   // ------------------------------------------------------------------

   // free-running 10 ms step pulse
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pre_q  <= '0;
         tick_q <= 1'b0;
      end else if (pre_q == PRE_LAST) begin
         pre_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         pre_q  <= pre_q + PRE_W'(1);
         tick_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // source selection and collective signal
   // ------------------------------------------------------------------

   ors_src_mux u_mux (
      .pool_i     (sig_pool_i),
      .src_cfg_i  (src_cfg_q),
      .ack_cfg_i  (ack_cfg_q),
      .coll_inv_i (ctrl_q.coll_inv),
      .coll_o     (coll),
      .ack_o      (ack)
   );

   // ------------------------------------------------------------------
   // latch stage
   // ------------------------------------------------------------------

   // pickup sets, acknowledgement clears; pickup wins a tie
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         latched_q <= 1'b0;
      end else if (!ctrl_q.latch_en) begin
         latched_q <= 1'b0;
      end else if (coll) begin
         latched_q <= 1'b1;
      end else if (ack) begin
         latched_q <= 1'b0;
      end
   end

   // demand is live signal or held pickup
   assign want = coll | latched_q;

   // ------------------------------------------------------------------
   // switch-off delay stage
   // ------------------------------------------------------------------

   // counts from the end of demand; held cleared while demand stands
   ors_tick_timer u_off_tmr (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .tick_i     (tick_q),
      .restart_i  (dly_q != DLY_RUN),
      .limit_i    (toff_q),
      .done_o     (off_done)
   );

   // next state of the switch-off stage
   always_comb begin
      dly_d = dly_q;
      case (dly_q)
         DLY_OFF: begin
            if (want) begin
               dly_d = DLY_ON;
            end
         end
         DLY_ON: begin
            if (!want) begin
               dly_d = (toff_q == TIME_RST) ? DLY_OFF : DLY_RUN;
            end
         end
         DLY_RUN: begin
            if (want) begin
               dly_d = DLY_ON;                                    // demand back, cancel
            end else if (off_done) begin
               dly_d = DLY_OFF;
            end
         end
         default: begin
            dly_d = DLY_OFF;                                      // recover from bad code
         end
      endcase
   end

   // switch-off stage register
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         dly_q <= DLY_OFF;
      end else begin
         dly_q <= dly_d;
      end
   end

   assign dly_on = (dly_q != DLY_OFF);                          // pickup not delayed

   // ------------------------------------------------------------------
   // minimum hold stage
   // ------------------------------------------------------------------

   // counts from the last relay change
   ors_tick_timer u_hold_tmr (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .tick_i     (tick_q),
      .restart_i  (change),
      .limit_i    (thold_q),
      .done_o     (hold_done)
   );

   // relay follows only once the previous state has been held long enough
   assign change = (dly_on != relay_q) && hold_done;

   // relay drive register
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         relay_q <= 1'b0;
      end else if (change) begin
         relay_q <= dly_on;
      end
   end

   // outputs straight from flip-flops
   assign relay_o     = relay_q;
   assign reg_rdata_o = rdata_q;

endmodule : ors_relay_top

// File: rtl/ors_pkg.sv
// Purpose: shared constants, types and register map of the output relay logic
// Assumes: 25 MHz core clock, 32-bit register port with byte addresses
// Notes:   all times are held in 10 ms steps, 0 to 300.00 s
package ors_pkg;

   // clock and time base
   localparam int unsigned CLK_HZ         = 25_000_000;        // core clock rate
   localparam int unsigned TICK_MS        = 10;                // time step of settings
   localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS; // cycles per step
   localparam int unsigned TIME_MAX_S     = 300;               // longest setting in seconds
   localparam int unsigned TIME_MAX_STEPS = TIME_MAX_S * 1000 / TICK_MS;

   // widths
   localparam int unsigned NUM_SRC = 7;                        // sources per output
   localparam int unsigned POOL_W  = 32;                       // internal signal pool
   localparam int unsigned IDX_W   = 5;                        // pool index width
   localparam int unsigned ADDR_W  = 8;                        // register address width
   localparam int unsigned DATA_W  = 32;                       // register data width
   localparam int unsigned TIME_W  = 15;                       // time setting width

   localparam logic [TIME_W-1:0] TIME_MAX = TIME_W'(TIME_MAX_STEPS); // clamp value
   localparam logic [TIME_W-1:0] TIME_RST = 15'h0000;                // 0.00 s default

   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] ADDR_ASSIGN0 = 8'h00;         // first source assignment
   localparam logic [ADDR_W-1:0] ADDR_STRIDE  = 8'h04;         // word spacing
   localparam logic [ADDR_W-1:0] ADDR_ACK     = 8'h1C;         // acknowledgement source
   localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h20;         // latch and collective invert
   localparam logic [ADDR_W-1:0] ADDR_THOLD   = 8'h24;         // minimum hold time
   localparam logic [ADDR_W-1:0] ADDR_TOFF    = 8'h28;         // switch-off delay
   localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h2C;         // live state, read only

   // field positions
   localparam int unsigned CFG_EN_BIT     = 7;                 // source assigned
   localparam int unsigned CFG_INV_BIT    = 6;                 // source inverted
   localparam int unsigned CTRL_LATCH_BIT = 0;                 // latching enabled
   localparam int unsigned CTRL_CINV_BIT  = 1;                 // collective inverted
   localparam int unsigned STS_RELAY_BIT  = 0;                 // relay driven
   localparam int unsigned STS_LATCH_BIT  = 1;                 // latched state held
   localparam int unsigned STS_COLL_BIT   = 2;                 // collective signal
   localparam int unsigned STS_DLY_BIT    = 3;                 // switch-off delay running
   localparam int unsigned STS_HOLD_BIT   = 4;                 // hold time running

   // one source or acknowledgement selection
   typedef struct packed {
      logic             en;                                    // assigned
      logic             inv;                                   // inverted
      logic [IDX_W-1:0] idx;                                   // pool index
   } ors_src_cfg_t;

   // output control settings
   typedef struct packed {
      logic latch_en;                                          // latch on pickup
      logic coll_inv;                                          // invert ored result
   } ors_ctrl_t;

   localparam ors_src_cfg_t CFG_RST  = '{en: 1'b0, inv: 1'b0, idx: 5'h00};
   localparam ors_ctrl_t    CTRL_RST = '{latch_en: 1'b0, coll_inv: 1'b0};

   // switch-off delay stage states
   typedef enum logic [2:0] {
      DLY_OFF = 3'b001,                                        // output released
      DLY_ON  = 3'b010,                                        // output demanded
      DLY_RUN = 3'b100                                         // waiting out the delay
   } ors_dly_state_t;

endpackage : ors_pkg

// File: rtl/ors_src_mux.sv
// Purpose: picks sources from the signal pool and forms the collective signal
// Assumes: pool signals are synchronous to the core clock
// Notes:   purely combinational; an unassigned source adds nothing to the or
module ors_src_mux (
   // signal pool
   input  wire logic [ors_pkg::POOL_W-1:0] pool_i,
   // selections
   input  ors_pkg::ors_src_cfg_t           src_cfg_i [ors_pkg::NUM_SRC],
   input  ors_pkg::ors_src_cfg_t           ack_cfg_i,
   input  wire logic                       coll_inv_i,
   // results
   output logic                            coll_o,
   output logic                            ack_o
);
   import ors_pkg::*;

   logic [NUM_SRC-1:0] term;                                   // per-source contribution

   // one selector per source
   for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
      // inverted or plain pool bit, gated by assignment
      assign term[g] = src_cfg_i[g].en & (pool_i[src_cfg_i[g].idx] ^ src_cfg_i[g].inv);
   end

   // or of all sources, then optional inversion
   assign coll_o = (|term) ^ coll_inv_i;

   // acknowledgement source, inactive when unassigned
   assign ack_o  = ack_cfg_i.en & pool_i[ack_cfg_i.idx];

endmodule : ors_src_mux

// File: rtl/ors_tick_timer.sv
// Purpose: counts time steps since the last restart against a limit
// Assumes: tick_i is a one-cycle pulse once per time step
// Notes:   done after limit+1 ticks, at once for a zero limit, so that at least limit full steps pass
module ors_tick_timer (
   // clock and reset
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_n_i,
   // control
   input  wire logic                       tick_i,
   input  wire logic                       restart_i,
   input  wire logic [ors_pkg::TIME_W-1:0] limit_i,
   // result
   output logic                            done_o
);
   import ors_pkg::*;

   logic [TIME_W:0] cnt_q;                                     // ticks seen, saturating

   // tick counter, cleared by restart, stops once done
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
      end else if (restart_i) begin
         cnt_q <= '0;
      end else if (tick_i && !done_o) begin
         cnt_q <= cnt_q + (TIME_W+1)'(1);
      end
   end

   // zero limit means no wait at all
   assign done_o = (limit_i == TIME_RST) || (cnt_q > {1'b0, limit_i});

endmodule : ors_tick_timer

// File: tb/ors_pool_model.sv
// Purpose: stands in for the internal signal pool feeding the relay logic
// Assumes: the bench states the wanted pool pattern in want_i
// Notes:   registered so pool levels change only just after a clock edge
module ors_pool_model (
   // clock
   input  wire logic                       core_clk_i,
   // wanted pattern and pool
   input  wire logic [ors_pkg::POOL_W-1:0] want_i,
   output logic      [ors_pkg::POOL_W-1:0] pool_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // pool follows the wanted pattern one edge later
   always_ff @(posedge core_clk_i) begin
      pool_o <= want_i;
   end
endmodule : ors_pool_model

// File: tb/ors_relay_checker.sv
// Purpose: assertions on the ports of the relay output logic
// Assumes: settings shadowed from register writes, no unaligned addresses
// Notes:   zero-time checks wait for a quiet register port
module ors_relay_checker
   import ors_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 4            // cycles per time step
) (
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic [ors_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [ors_pkg::DATA_W-1:0] reg_wdata_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   input  wire logic [ors_pkg::DATA_W-1:0] reg_rdata_o,
   input  wire logic [ors_pkg::POOL_W-1:0] sig_pool_i,
   input  wire logic                       relay_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]        cfg_q [8];                     // shadow selections, 7 is ack
   logic [1:0]        ctrl_q;                        // shadow latch and invert
   logic [TIME_W-1:0] hold_q;                        // shadow hold time
   logic [TIME_W-1:0] toff_q;                        // shadow off delay
   logic [2:0]        quiet_q;                       // edges since last write
   logic              prev_q;                        // relay one cycle ago
   logic              moved_q;                       // relay changed since reset
   logic [31:0]       run_q;                         // cycles relay held its value
   logic              coll_c;                        // reference collective
   logic              ack_c;                         // reference acknowledgement
   logic              tz;                            // all times zero
   logic              chg;                           // relay changed

   // shadow settings, time writes clamped
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cfg_q  <= '{default: 8'h00};
         ctrl_q <= 2'h0;
         hold_q <= 15'h0000;
         toff_q <= 15'h0000;
      end else if (reg_wr_i) begin
         if (reg_addr_i < ADDR_CTRL) cfg_q[reg_addr_i[4:2]] <= reg_wdata_i[7:0];
         if (reg_addr_i == ADDR_CTRL) ctrl_q <= reg_wdata_i[1:0];
         if (reg_addr_i == ADDR_THOLD)
            hold_q <= (reg_wdata_i > 32'(TIME_MAX)) ? TIME_MAX : reg_wdata_i[TIME_W-1:0];
         if (reg_addr_i == ADDR_TOFF)
            toff_q <= (reg_wdata_i > 32'(TIME_MAX)) ? TIME_MAX : reg_wdata_i[TIME_W-1:0];
      end
   end

   // reference or of inverted sources
   always_comb begin
      coll_c = 1'b0;
      for (int i = 0; i < 7; i++) begin
         coll_c = coll_c | (cfg_q[i][7] & (sig_pool_i[cfg_q[i][4:0]] ^ cfg_q[i][6]));
      end
      coll_c = coll_c ^ ctrl_q[1];
   end
   assign ack_c = cfg_q[7][7] & sig_pool_i[cfg_q[7][4:0]];
   assign tz    = (hold_q == 15'h0000) && (toff_q == 15'h0000);
   assign chg   = relay_o != prev_q;

   // port quiet time and relay run length
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         quiet_q <= 3'h0;
         prev_q  <= 1'b0;
         moved_q <= 1'b0;
         run_q   <= 32'h0;
      end else begin
         quiet_q <= reg_wr_i ? 3'h0 : ((quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1);
         prev_q  <= relay_o;
         moved_q <= moved_q | chg;
         run_q   <= chg ? 32'h1 : run_q + 32'h1;
      end
   end

   chk_rdata_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data outside read slot");
   chk_rdata_unmapped: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $past(reg_rd_i) && ($past(reg_addr_i) > ADDR_STATUS) |-> reg_rdata_o == 32'h0)
      else $error("unmapped read not zero");
   chk_reset_low: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> !relay_o ##1 !relay_o) else $error("relay up after reset");
   chk_pickup_two: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      tz && quiet_q >= 3'h4 && $past(coll_c, 2) |-> relay_o) else $error("pickup late");
   chk_release_two: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      tz && !ctrl_q[0] && quiet_q >= 3'h4 && !$past(coll_c, 2) |-> !relay_o)
      else $error("release late");
   chk_latch_keep: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ctrl_q[0] && tz && quiet_q >= 3'h5 && $past(relay_o) && !$past(ack_c, 3) |-> relay_o)
      else $error("latched relay dropped");
   chk_ack_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ctrl_q[0] && tz && quiet_q >= 3'h5 && $past(ack_c, 3) && !$past(coll_c, 3)
      && !$past(coll_c, 2) |-> !relay_o) else $error("ack did not clear");
   chk_hold_min: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      chg && moved_q |-> run_q >= 32'(hold_q) * TICK_CYCLES) else $error("state held too short");
endmodule : ors_relay_checker

bind ors_relay_top ors_relay_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .sig_pool_i(sig_pool_i), .relay_o(relay_o));

// File: tb/tb_output_relay_signal_logic.sv
// Purpose: self-checking bench of the relay output logic
// Assumes: short time step of 4 cycles
// Notes:   scenarios ordered so zero-time checks precede hold and delay
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
module tb_output_relay_signal_logic;
   timeunit 1ns;
   timeprecision 1ns;
   import ors_pkg::*;
   localparam int unsigned TC = 4;                   // cycles per time step
   logic               core_clk_i  = 1'b0;           // 25 MHz clock
   logic               rst_n_i     = 1'b0;           // reset, active low
   logic [ADDR_W-1:0]  reg_addr_i  = 8'h00;          // register port
   logic [DATA_W-1:0]  reg_wdata_i = 32'h0;
   logic               reg_wr_i    = 1'b0;
   logic               reg_rd_i    = 1'b0;
   logic [DATA_W-1:0]  reg_rdata_o;
   logic [POOL_W-1:0]  want_q      = 32'h0;          // wanted pool pattern
   logic [POOL_W-1:0]  sig_pool_i;                   // pool seen by the block
   logic               relay_o;
   int                 n_fail      = 0;
   int                 n_compared  = 0;
   int                 n;                            // measured cycles

   always #20 core_clk_i = ~core_clk_i;

   ors_pool_model u_pool (.core_clk_i(core_clk_i), .want_i(want_q), .pool_o(sig_pool_i));
   ors_relay_top #(.TICK_CYCLES(TC)) uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sig_pool_i(sig_pool_i),
      .relay_o(relay_o));

   task automatic give_verdict();
      $display("n_fail=%0d n_compared=%0d", n_fail, n_compared);
      if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   // one-cycle read, data judged in the following cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge core_clk_i);
      `CHK(reg_rdata_o, e)
   endtask : rd
   task automatic pool(input logic [31:0] v, input int wait_n);
      @(posedge core_clk_i);
      want_q <= v;
      repeat (wait_n) @(posedge core_clk_i);
   endtask : pool
   task automatic relay_is(input logic e);
      @(negedge core_clk_i);
      `CHK(relay_o, e)
   endtask : relay_is
   // bounded wait for a relay level, cycles returned in n
   task automatic wait_relay(input logic v, input int lim);
      n = 0;
      @(negedge core_clk_i);
      while (relay_o !== v && n < lim) begin
         @(negedge core_clk_i);
         n++;
      end
      if (n >= lim) begin
         n_fail++;
         $display("ERROR %0t: relay wait timed out", $time);
         give_verdict();
      end
   endtask : wait_relay

   // reset values, unmapped and read-only places
   task automatic s_reset();
      for (int a = 0; a <= 16'h30; a += 4) rd(8'(a), 32'h0);
      rd(8'hFC, 32'h0);
      wr(ADDR_STATUS, 32'hFFFFFFFF);
      rd(ADDR_STATUS, 32'h0);
   endtask : s_reset
   // or of seven sources, source and collective inversion
   task automatic s_or();
      logic [31:0] pv [9] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h20, 32'h40, 32'h0,
                              32'hFFFFFF80};
      for (int i = 0; i < 7; i++) wr(8'(4 * i), 32'h80 | i);
      for (int i = 0; i < 9; i++) begin
         pool(pv[i], 4);
         relay_is(|pv[i][6:0]);
      end
      wr(8'h08, 32'hC2);
      rd(8'h08, 32'hC2);
      pool(32'h0, 4);
      relay_is(1'b1);
      for (int i = 0; i < 7; i++) wr(8'(4 * i), 32'hC0 | i);
      wr(ADDR_CTRL, 32'h2);
      pool(32'h7F, 4);
      relay_is(1'b1);
      pool(32'h3F, 4);
      relay_is(1'b0);
      wr(ADDR_CTRL, 32'h0);
      for (int i = 1; i < 7; i++) wr(8'(4 * i), 32'h0);
      wr(ADDR_ASSIGN0, 32'h80);
   endtask : s_or
   // latching, acknowledgement and its ignoring
   task automatic s_latch();
      wr(ADDR_ACK, 32'hCA);
      rd(ADDR_ACK, 32'h8A);
      wr(ADDR_CTRL, 32'h1);
      pool(32'h1, 4);
      pool(32'h0, 8);
      relay_is(1'b1);
      rd(ADDR_STATUS, 32'h3);
      pool(32'h401, 4);
      pool(32'h0, 8);
      relay_is(1'b1);
      pool(32'h400, 1);
      pool(32'h0, 5);
      relay_is(1'b0);
      wr(ADDR_CTRL, 32'h0);
      pool(32'h401, 4);
      relay_is(1'b1);
      pool(32'h0, 4);
      relay_is(1'b0);
   endtask : s_latch
   // release delayed by whole steps, pickup not, return cancels
   task automatic s_delay();
      wr(ADDR_TOFF, 32'h3);
      pool(32'h1, 0);
      wait_relay(1'b1, 8);
      `CHK(n <= 3, 1'b1)
      pool(32'h0, 6);
      rd(ADDR_STATUS, 32'h9);
      pool(32'h1, 24);
      relay_is(1'b1);
      pool(32'h0, 0);
      wait_relay(1'b0, 40);
      `CHK(n >= 3 * TC && n <= 4 * TC + 4, 1'b1)
      wr(ADDR_TOFF, 32'h0);
   endtask : s_delay
   // minimum hold of a short pulse, clamped setting
   task automatic s_hold();
      wr(ADDR_THOLD, 32'h5);
      pool(32'h0, 8 * TC);
      pool(32'h1, 1);
      pool(32'h0, 0);
      wait_relay(1'b1, 8);
      rd(ADDR_STATUS, 32'h11);
      wait_relay(1'b0, 60);
      `CHK(n >= 5 * TC - 1 && n <= 6 * TC + 4, 1'b1)
      wr(ADDR_THOLD, 32'hFFFF);
      rd(ADDR_THOLD, 32'h7530);
   endtask : s_hold

   initial begin
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      s_reset();
      s_or();
      s_latch();
      s_delay();
      s_hold();
      give_verdict();
   end
endmodule : tb_output_relay_signal_logic
